// ---- verilog/scrb_pkg.sv ----
// scrb_pkg: constants shared by the synthesizer control register bank
package scrb_pkg;
  // register word and address widths
  localparam int SCRB_DATA_W = 18;
  localparam int SCRB_ADDR_W = 4;
  // serial frame: data bits 17..0 first, then address bits 3..0
  localparam int SCRB_FRAME_W = SCRB_DATA_W + SCRB_ADDR_W;
  localparam logic [4:0] SCRB_FRAME_LEN = 5'h16;
  // register addresses
  localparam logic [3:0] SCRB_ADDR_MAIN = 4'h0;
  localparam logic [3:0] SCRB_ADDR_GAIN = 4'h1;
  localparam logic [3:0] SCRB_ADDR_POWER = 4'h2;
  localparam logic [3:0] SCRB_ADDR_RF1_N = 4'h3;
  localparam logic [3:0] SCRB_ADDR_RF2_N = 4'h4;
  localparam logic [3:0] SCRB_ADDR_IF_N = 4'h5;
  // main configuration field positions
  localparam int SCRB_AUX_OUTPUT_SELECT_LSB = 12;
  localparam int SCRB_IF_OUTPUT_DIVIDE_LSB = 10;
  localparam int SCRB_REFHALF_BIT = 6;
  localparam int SCRB_LOWPWR_BIT = 5;
  localparam int SCRB_AUTOUP_BIT = 3;
  // gain field positions
  localparam int SCRB_IF_GAIN_LSB = 4;
  localparam int SCRB_RF2_GAIN_LSB = 2;
  localparam int SCRB_RF1_GAIN_LSB = 0;
  // power control bit positions
  localparam int SCRB_IF_ON_BIT = 1;
  localparam int SCRB_RF_ON_BIT = 0;
  // divider field widths
  localparam int SCRB_RF2_N_W = 17;
  localparam int SCRB_IF_N_W = 16;
  // auxiliary output select codes
  localparam logic [1:0] SCRB_AUX_FORCE_LOW = 2'h1;
  localparam logic [1:0] SCRB_AUX_LOCK_WARN = 2'h3;
  // reset values of the stored fields
  localparam logic [1:0] SCRB_RST_FIELD2 = 2'h0;
  localparam logic SCRB_RST_BIT = 1'b0;
  localparam logic [17:0] SCRB_RST_WORD = 18'h0_0000;
  localparam logic [4:0] SCRB_RST_COUNT = 5'h00;
endpackage : scrb_pkg

// ---- verilog/scrb_serial_rx.sv ----
// scrb_serial_rx: three-wire serial receiver delivering address and data words
`timescale 1ns/1ps
`default_nettype none
module scrb_serial_rx
  import scrb_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // serial pins, sampled on i_clk
  input wire logic i_serial_enable_n,
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  // received word
  output logic o_word_valid,
  output logic [SCRB_ADDR_W-1:0] o_word_addr,
  output logic [SCRB_DATA_W-1:0] o_word_data
);

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the sampled pins
  logic sclk_prev_reg; // serial clock one sample ago
  logic en_prev_reg; // enable one sample ago
  logic [SCRB_FRAME_W-1:0] shift_reg; // last bits shifted in
  logic [SCRB_FRAME_W-1:0] shift_next;
  logic [4:0] count_reg; // bits seen in this frame, saturating
  logic [4:0] count_next;
  logic valid_reg;
  logic [SCRB_ADDR_W-1:0] addr_reg;
  logic [SCRB_DATA_W-1:0] data_reg;
  wire sclk_rise = i_serial_clock & ~sclk_prev_reg;
  wire frame_active = ~i_serial_enable_n;
  wire frame_end = i_serial_enable_n & ~en_prev_reg;
  // a short or long frame is dropped; only exact lengths are trusted
  wire frame_good = frame_end && (count_reg == SCRB_FRAME_LEN);

  // shift on rising serial clock while the frame is open
  assign shift_next = (frame_active && sclk_rise) ? {shift_reg[SCRB_FRAME_W-2:0], i_serial_data} : shift_reg;
  // count restarts each frame and sticks one past the frame length
  assign count_next = !frame_active ? SCRB_RST_COUNT :
                      (sclk_rise && count_reg <= SCRB_FRAME_LEN) ? count_reg + 5'h01 : count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sclk_prev_reg <= 1'b0;
      en_prev_reg <= 1'b1;
      shift_reg <= '0;
      count_reg <= SCRB_RST_COUNT;
      valid_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= SCRB_RST_WORD;
    end
    else
    begin
      sclk_prev_reg <= i_serial_clock;
      en_prev_reg <= i_serial_enable_n;
      shift_reg <= shift_next;
      count_reg <= count_next;
      valid_reg <= frame_good;
      // data bits arrive first, address bits last
      if (frame_good)
      begin
        addr_reg <= shift_reg[SCRB_ADDR_W-1:0];
        data_reg <= shift_reg[SCRB_FRAME_W-1:SCRB_ADDR_W];
      end
    end
  end

  assign o_word_valid = valid_reg;
  assign o_word_addr = addr_reg;
  assign o_word_data = data_reg;

endmodule : scrb_serial_rx
`default_nettype wire

// ---- verilog/scrb_bank.sv ----
// scrb_bank: write-only control register bank of the dual-band synthesizer
// What this block does
// - main config: IF divide, reference halve, buffer, autopowerup
// - gain register holds three two-bit detector gains
// - power register: bit1 IF on, bit0 RF on
// - address three holds full eighteen-bit RF1 count
// - address four holds RF2 count, at least 240; bank stores any value unclamped and resets it to 0
// - address five holds IF count, at least 56; bank stores any value unclamped and resets it to 0
// - power pin low turns both sections off
// - aux select routes lock-loss warning to pin
// - writes accepted in every powerdown state
`timescale 1ns/1ps
`default_nettype none
module scrb_bank
  import scrb_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // three-wire serial port
  input wire logic i_serial_enable_n,
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  // power pin and analog status
  input wire logic i_power_off_pin_n,
  input wire logic i_lock_loss_warning,
  // main configuration fields
  output logic [1:0] o_aux_output_select,
  output logic [1:0] o_if_output_divide,
  output logic o_reference_halve,
  output logic o_if_buffer_low_power,
  output logic o_automatic_powerup,
  // detector gains
  output logic [1:0] o_if_detector_gain,
  output logic [1:0] o_rf_band2_detector_gain,
  output logic [1:0] o_rf_band1_detector_gain,
  // section power
  output logic o_if_section_on,
  output logic o_rf_section_on,
  output logic o_if_powered,
  output logic o_rf_powered,
  // feedback counts
  output logic [SCRB_DATA_W-1:0] o_rf_band1_feedback_count,
  output logic [SCRB_RF2_N_W-1:0] o_rf_band2_feedback_count,
  output logic [SCRB_IF_N_W-1:0] o_if_feedback_count,
  // auxiliary pin
  output logic o_auxiliary_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver
  logic word_valid; // one-cycle pulse per complete frame
  logic [SCRB_ADDR_W-1:0] word_addr;
  logic [SCRB_DATA_W-1:0] word_data;

  // receiver runs regardless of power pin state
  scrb_serial_rx u_rx (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_serial_enable_n(i_serial_enable_n),
    .i_serial_clock(i_serial_clock),
    .i_serial_data(i_serial_data),
    .o_word_valid(word_valid),
    .o_word_addr(word_addr),
    .o_word_data(word_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode; addresses six and up are ignored
  // the host keeps off nine to fifteen; dropping them keeps state safe
  // one compare shared by every register strobe; a frame that failed its
  // length check never raises the valid pulse, so no strobe can fire
  function automatic logic addr_hit(input logic valid, input logic [SCRB_ADDR_W-1:0] got,
    input logic [SCRB_ADDR_W-1:0] want);
    return valid && (got == want);
  endfunction : addr_hit

  // one strobe per register, each a single cycle wide
  wire wr_main = addr_hit(word_valid, word_addr, SCRB_ADDR_MAIN);
  wire wr_gain = addr_hit(word_valid, word_addr, SCRB_ADDR_GAIN);
  wire wr_power = addr_hit(word_valid, word_addr, SCRB_ADDR_POWER);
  wire wr_rf1 = addr_hit(word_valid, word_addr, SCRB_ADDR_RF1_N);
  wire wr_rf2 = addr_hit(word_valid, word_addr, SCRB_ADDR_RF2_N);
  wire wr_if = addr_hit(word_valid, word_addr, SCRB_ADDR_IF_N);

  ////////////////////////////////////////////////////////////////////////////
  // stored fields; reserved bits are not kept
  // reset to zero keeps both sections off until the host has written
  logic [1:0] aux_output_select_reg;
  logic [1:0] if_output_divide_reg;
  logic refhalf_reg;
  logic lowpwr_reg;
  logic autoup_reg;
  logic [1:0] if_gain_reg;
  logic [1:0] rf2_gain_reg;
  logic [1:0] rf1_gain_reg;
  logic if_on_reg;
  logic rf_on_reg;
  logic [SCRB_DATA_W-1:0] rf1_n_reg;
  logic [SCRB_RF2_N_W-1:0] rf2_n_reg;
  logic [SCRB_IF_N_W-1:0] if_n_reg;
  logic if_pwr_reg;
  logic rf_pwr_reg;
  logic aux_reg;

  // power decision: pin overrides, auto powerup overrides register
  wire pin_on = i_power_off_pin_n;
  wire if_pwr_next = pin_on & (autoup_reg | if_on_reg);
  wire rf_pwr_next = pin_on & (autoup_reg | rf_on_reg);
  // aux routing: lock warning, forced low, otherwise low
  wire aux_next = (aux_output_select_reg == SCRB_AUX_LOCK_WARN) ? i_lock_loss_warning : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // main configuration and gain registers, hold until rewritten
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      aux_output_select_reg <= SCRB_RST_FIELD2;
      if_output_divide_reg <= SCRB_RST_FIELD2;
      refhalf_reg <= SCRB_RST_BIT;
      lowpwr_reg <= SCRB_RST_BIT;
      autoup_reg <= SCRB_RST_BIT;
      if_gain_reg <= SCRB_RST_FIELD2;
      rf2_gain_reg <= SCRB_RST_FIELD2;
      rf1_gain_reg <= SCRB_RST_FIELD2;
    end
    else
    begin
      // main configuration fields
      if (wr_main)
      begin
        aux_output_select_reg <= word_data[SCRB_AUX_OUTPUT_SELECT_LSB +: 2];
        if_output_divide_reg <= word_data[SCRB_IF_OUTPUT_DIVIDE_LSB +: 2];
        refhalf_reg <= word_data[SCRB_REFHALF_BIT];
        lowpwr_reg <= word_data[SCRB_LOWPWR_BIT];
        autoup_reg <= word_data[SCRB_AUTOUP_BIT];
      end
      // gain codes
      if (wr_gain)
      begin
        if_gain_reg <= word_data[SCRB_IF_GAIN_LSB +: 2];
        rf2_gain_reg <= word_data[SCRB_RF2_GAIN_LSB +: 2];
        rf1_gain_reg <= word_data[SCRB_RF1_GAIN_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control and divider registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      if_on_reg <= SCRB_RST_BIT;
      rf_on_reg <= SCRB_RST_BIT;
      rf1_n_reg <= SCRB_RST_WORD;
      rf2_n_reg <= SCRB_RST_WORD[SCRB_RF2_N_W-1:0];
      if_n_reg <= SCRB_RST_WORD[SCRB_IF_N_W-1:0];
    end
    else
    begin
      // section enable bits
      if (wr_power)
      begin
        if_on_reg <= word_data[SCRB_IF_ON_BIT];
        rf_on_reg <= word_data[SCRB_RF_ON_BIT];
      end
      // full-width count
      if (wr_rf1)
        rf1_n_reg <= word_data;
      // the host keeps the minimum; no clamping here
      if (wr_rf2)
        rf2_n_reg <= word_data[SCRB_RF2_N_W-1:0];
      // the host keeps the minimum; no clamping here
      if (wr_if)
        if_n_reg <= word_data[SCRB_IF_N_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered power and aux outputs, one cycle behind their inputs
  // the pin is taken as already synchronous; a pin from another domain
  // needs a two-stage synchroniser in front of this block
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      if_pwr_reg <= SCRB_RST_BIT;
      rf_pwr_reg <= SCRB_RST_BIT;
      aux_reg <= SCRB_RST_BIT;
    end
    else
    begin
      if_pwr_reg <= if_pwr_next;
      rf_pwr_reg <= rf_pwr_next;
      aux_reg <= aux_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign o_aux_output_select = aux_output_select_reg;
  assign o_if_output_divide = if_output_divide_reg;
  assign o_reference_halve = refhalf_reg;
  assign o_if_buffer_low_power = lowpwr_reg;
  assign o_automatic_powerup = autoup_reg;
  assign o_if_detector_gain = if_gain_reg;
  assign o_rf_band2_detector_gain = rf2_gain_reg;
  assign o_rf_band1_detector_gain = rf1_gain_reg;
  assign o_if_section_on = if_on_reg;
  assign o_rf_section_on = rf_on_reg;
  assign o_if_powered = if_pwr_reg;
  assign o_rf_powered = rf_pwr_reg;
  assign o_rf_band1_feedback_count = rf1_n_reg;
  assign o_rf_band2_feedback_count = rf2_n_reg;
  assign o_if_feedback_count = if_n_reg;
  assign o_auxiliary_pin = aux_reg;

endmodule : scrb_bank
`default_nettype wire

// ---- tb/scrb_bank_properties.sv ----
// scrb_bank_properties: concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module scrb_bank_properties
  import scrb_pkg::*;
(
  // clock, reset and pins
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_serial_enable_n,
  input wire logic i_power_off_pin_n,
  input wire logic i_lock_loss_warning,
  // watched outputs
  input wire logic [1:0] o_aux_output_select,
  input wire logic o_automatic_powerup,
  input wire logic [1:0] o_if_detector_gain,
  input wire logic o_if_section_on,
  input wire logic o_rf_section_on,
  input wire logic o_if_powered,
  input wire logic o_rf_powered,
  input wire logic [SCRB_DATA_W-1:0] o_rf_band1_feedback_count,
  input wire logic [SCRB_IF_N_W-1:0] o_if_feedback_count,
  input wire logic o_auxiliary_pin
);
  ////////////////////////////////////////////////////////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // aux pin follows the warning only under the lock-warning code
  a_aux_lock_route: assert property (o_auxiliary_pin == $past(o_aux_output_select == 2'h3 && i_lock_loss_warning))
    else $error("aux pin routing wrong");
  // section power is the pin gated with register or automatic powerup
  a_if_power_gate: assert property (o_if_powered == $past(i_power_off_pin_n && (o_automatic_powerup || o_if_section_on)))
    else $error("if power wrong");
  a_rf_power_gate: assert property (o_rf_powered == $past(i_power_off_pin_n && (o_automatic_powerup || o_rf_section_on)))
    else $error("rf power wrong");
  a_pin_off_both: assert property (!i_power_off_pin_n |=> !o_if_powered && !o_rf_powered)
    else $error("pin low left a section on");
  a_auto_powers_all: assert property (o_automatic_powerup && i_power_off_pin_n |=> o_if_powered && o_rf_powered)
    else $error("automatic powerup ignored");
  // with no frame in flight the RF1 and IF counts may not move
  a_idle_fields_hold: assert property (i_serial_enable_n [*5] |-> $stable(o_rf_band1_feedback_count) && $stable(o_if_feedback_count))
    else $error("stored field moved while idle");
  // a stored word moves exactly two edges after the frame closes
  a_count_change_time: assert property ($changed(o_rf_band1_feedback_count) |-> $past(i_serial_enable_n, 2) && !$past(i_serial_enable_n, 3))
    else $error("count changed at wrong time");
  a_gain_change_time: assert property ($changed(o_if_detector_gain) |-> $past(i_serial_enable_n, 2) && !$past(i_serial_enable_n, 3))
    else $error("gain changed at wrong time");
  // main scenarios reached
  c_auto_on: cover property (o_automatic_powerup && o_if_powered);
  c_aux_warn: cover property (o_auxiliary_pin);
  c_pin_off_on: cover property (!i_power_off_pin_n && o_if_section_on);
endmodule : scrb_bank_properties
`default_nettype wire

// ---- tb/scrb_host_model.sv ----
// scrb_host_model: host controller driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module scrb_host_model
  import scrb_pkg::*;
(
  // clock
  input wire logic i_clk,
  // serial pins toward the bank
  output logic o_serial_enable_n,
  output logic o_serial_clock,
  output logic o_serial_data
);
  ////////////////////////////////////////////////////////////
  // idle: enable high, serial clock standing still low
  initial
  begin
    o_serial_enable_n = 1'b1;
    o_serial_clock = 1'b0;
    o_serial_data = 1'b0;
  end
  // one frame, data msb first then address; callers keep addresses at 8 and below
  task automatic send(input logic [SCRB_ADDR_W-1:0] addr, input logic [SCRB_DATA_W-1:0] data);
    logic [SCRB_FRAME_W-1:0] frame;
    frame = {data, addr};
    @(posedge i_clk);
    o_serial_enable_n <= 1'b0;
    for (int i = SCRB_FRAME_W - 1; i >= 0; i--)
    begin
      o_serial_data <= frame[i];
      o_serial_clock <= 1'b0;
      @(posedge i_clk);
      o_serial_clock <= 1'b1;
      @(posedge i_clk);
    end
    // released data shows the inverse so a stale bit cannot pass as good
    o_serial_enable_n <= 1'b1;
    o_serial_clock <= 1'b0;
    o_serial_data <= ~frame[0];
  endtask : send
  // main word always carries the fixed reserved pattern
  task automatic send_main(input logic [1:0] aux, input logic [1:0] div, input logic rh, input logic lp, input logic au);
    send(SCRB_ADDR_MAIN, {4'h0, aux, div, 3'b110, rh, lp, 1'b0, au, 1'b0, 1'b1, 1'b0});
  endtask : send_main
endmodule : scrb_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the synthesizer control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  import scrb_pkg::*;
  ////////////////////////////////////////////////////////////
  // stimulus and observed outputs
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic pin_n = 1'b1;
  logic lock = 1'b0;
  logic en_n, sclk, sdat;
  logic [1:0] aux_sel, if_div, if_gain, rf2_gain, rf1_gain;
  logic ref_half, low_pwr, auto_up, if_on, rf_on, if_pwr, rf_pwr, aux_pin;
  logic [17:0] rf1_n;
  logic [16:0] rf2_n;
  logic [15:0] if_n;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  scrb_host_model u_scrb_host_model (.i_clk(i_clk), .o_serial_enable_n(en_n), .o_serial_clock(sclk),
    .o_serial_data(sdat));
  scrb_bank u_scrb_bank (.i_clk(i_clk), .i_reset(i_reset), .i_serial_enable_n(en_n), .i_serial_clock(sclk),
    .i_serial_data(sdat), .i_power_off_pin_n(pin_n), .i_lock_loss_warning(lock),
    .o_aux_output_select(aux_sel), .o_if_output_divide(if_div), .o_reference_halve(ref_half),
    .o_if_buffer_low_power(low_pwr), .o_automatic_powerup(auto_up), .o_if_detector_gain(if_gain),
    .o_rf_band2_detector_gain(rf2_gain), .o_rf_band1_detector_gain(rf1_gain), .o_if_section_on(if_on),
    .o_rf_section_on(rf_on), .o_if_powered(if_pwr), .o_rf_powered(rf_pwr), .o_rf_band1_feedback_count(rf1_n),
    .o_rf_band2_feedback_count(rf2_n), .o_if_feedback_count(if_n), .o_auxiliary_pin(aux_pin));
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // hang guard, well above the roughly 1060 cycles the run needs
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // one write, then time for the word and the power outputs to land
  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    u_scrb_host_model.send(a, d);
    repeat (6) @(posedge i_clk);
  endtask : wr
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    `CHK("rf1 count at reset", 18'h0_0000, rf1_n)
    `CHK("if power at reset", 1'b0, if_pwr)
    // every aux, divide, gain and power code
    for (int i = 0; i < 4; i++)
    begin
      u_scrb_host_model.send_main(2'(i), 2'(3 - i), i[0], i[1], 1'b0);
      repeat (6) @(posedge i_clk);
      `CHK("aux select", 2'(i), aux_sel)
      `CHK("if divide", 2'(3 - i), if_div)
      `CHK("reference halve", 1'(i[0]), ref_half)
      `CHK("buffer low power", 1'(i[1]), low_pwr)
      `CHK("automatic powerup", 1'b0, auto_up)
      wr(SCRB_ADDR_GAIN, {12'h000, 2'(i), 2'(3 - i), 2'(i ^ 1)});
      `CHK("if gain", 2'(i), if_gain)
      `CHK("rf2 gain", 2'(3 - i), rf2_gain)
      `CHK("rf1 gain", 2'(i ^ 1), rf1_gain)
      wr(SCRB_ADDR_POWER, {16'h0000, 2'(i)});
      `CHK("if on bit", 1'(i[1]), if_on)
      `CHK("rf on bit", 1'(i[0]), rf_on)
      `CHK("if powered", 1'(i[1]), if_pwr)
      `CHK("rf powered", 1'(i[0]), rf_pwr)
    end
    lock <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("aux pin warning", 1'b1, aux_pin)
    // pin low, back-to-back writes at the minimum counts
    pin_n <= 1'b0;
    u_scrb_host_model.send(SCRB_ADDR_RF1_N, 18'h2_A5A5);
    u_scrb_host_model.send(SCRB_ADDR_RF2_N, {1'b0, 17'h0_00F0});
    wr(SCRB_ADDR_IF_N, {2'b00, 16'h0038});
    `CHK("if off by pin", 1'b0, if_pwr)
    `CHK("rf off by pin", 1'b0, rf_pwr)
    `CHK("rf1 count pin low", 18'h2_A5A5, rf1_n)
    `CHK("rf2 count min", 17'h0_00F0, rf2_n)
    `CHK("if count min", 16'h0038, if_n)
    `CHK("if on kept", 1'b1, if_on)
    pin_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("rf powered again", 1'b1, rf_pwr)
    // an address outside the bank leaves everything alone
    wr(4'h6, 18'h3_FFFF);
    `CHK("rf1 count kept", 18'h2_A5A5, rf1_n)
    u_scrb_host_model.send(SCRB_ADDR_RF1_N, 18'h3_FFFF);
    u_scrb_host_model.send(SCRB_ADDR_RF2_N, {1'b0, 17'h1_FFFF});
    wr(SCRB_ADDR_IF_N, {2'b00, 16'hFFFF});
    `CHK("rf1 count full", 18'h3_FFFF, rf1_n)
    `CHK("rf2 count full", 17'h1_FFFF, rf2_n)
    `CHK("if count full", 16'hFFFF, if_n)
    // automatic powerup overrides a cleared power register
    wr(SCRB_ADDR_POWER, 18'h0_0000);
    u_scrb_host_model.send_main(2'h1, 2'h0, 1'b0, 1'b0, 1'b1);
    repeat (6) @(posedge i_clk);
    `CHK("auto if powered", 1'b1, if_pwr)
    `CHK("auto rf powered", 1'b1, rf_pwr)
    `CHK("aux forced low", 1'b0, aux_pin)
    wrap_up();
  end
endmodule : tb_top
bind scrb_bank scrb_bank_properties u_scrb_bank_properties (.i_clk(i_clk), .i_reset(i_reset),
  .i_serial_enable_n(i_serial_enable_n), .i_power_off_pin_n(i_power_off_pin_n),
  .i_lock_loss_warning(i_lock_loss_warning), .o_aux_output_select(o_aux_output_select),
  .o_automatic_powerup(o_automatic_powerup), .o_if_detector_gain(o_if_detector_gain),
  .o_if_section_on(o_if_section_on), .o_rf_section_on(o_rf_section_on), .o_if_powered(o_if_powered),
  .o_rf_powered(o_rf_powered), .o_rf_band1_feedback_count(o_rf_band1_feedback_count),
  .o_if_feedback_count(o_if_feedback_count), .o_auxiliary_pin(o_auxiliary_pin));
`default_nettype wire
